//--- rtl/pwm_timer_pkg.sv
package pwm_timer_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int CTRL_W = 4;
   localparam int CLKP_W = 3;
   localparam int ACC_W  = 29;

   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_HIGH     = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LOW      = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_ON       = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_CLKPER   = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_SET_FRZ  = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_CLR_FRZ  = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h20;

   localparam int CTRL_CSS_BIT   = 0;
   localparam int CTRL_DIV10_BIT = 1;
   localparam int CTRL_RUN_BIT   = 2;
   localparam int CTRL_BURST_BIT = 3;
   localparam int CLKP_EN_BIT    = 0;
   localparam int CLKP_DIV_LSB   = 1;
   localparam int FRZ_BIT        = 0;
   localparam int IRQ_EV_BIT     = 0;

   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [CLKP_W-1:0] CLKP_RST = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;

   localparam logic [ACC_W-1:0] SYS_CLK_HZ   = 29'd250_000_000;
   localparam logic [ACC_W-1:0] FAST_BASE_HZ = 29'd16_000_000;
   localparam logic [ACC_W-1:0] SLOW_HZ      = 29'd32_000;

   localparam logic [3:0] DIV10_LAST = 4'h9;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_HIGH = 2'b01,
      ST_LOW  = 2'b10
   } phase_state_t;

endpackage : pwm_timer_pkg

//--- rtl/dual_phase_pwm_timer.sv
// Functional notes
// R01 - Counters and value registers reset to zero.
// R02 - Clock from 16/8/4/2 MHz or 32 kHz.
// R03 - Fast clocks need select bit and enable.
// R04 - Optional divide by ten for ON-counter only.
// R05 - Run bit starts timer, loads counters, interrupts.
// R06 - Phase zero flips toggle, alternates reload values.
// R07 - Primary high in high phase; secondary inverted.
// R08 - Burst mode outputs half timer clock in high.
// R09 - ON-counter holds zero until low phase ends.
// R10 - Interrupt point reloads counters and shadows.
// R11 - Reload writes reach shadows only at interrupt.
// R12 - Starting the timer interrupts immediately.
// R13 - Disabled timer holds logic in reset.
// R14 - ON address reads live ON-counter.
// R15 - Reload addresses read live phase counter.
// R16 - Freeze stops counters; clear freeze resumes.
// R17 - Sixteen-bit counters and value registers.
// R18 - Interrupt is one clock-wide pulse.
//
// Chosen here: the strobed register port and the register offsets.
module dual_phase_pwm_timer
(
   input  wire logic                             core_clk,
   input  wire logic                             sys_rst,
   input  wire logic [pwm_timer_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [pwm_timer_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [pwm_timer_pkg::DATA_W-1:0] reg_rdata,
   output logic                                  primary_pulse_out,
   output logic                                  inverted_pulse_out,
   output logic                                  timer_interrupt,
   output logic                                  irq
);

   typedef struct packed
   {
      logic [pwm_timer_pkg::CTRL_W-1:0] ctrl;
      logic [pwm_timer_pkg::CLKP_W-1:0] clkper;
      logic                             freeze;
      logic [pwm_timer_pkg::CNT_W-1:0]  high_reg;
      logic [pwm_timer_pkg::CNT_W-1:0]  low_reg;
      logic [pwm_timer_pkg::CNT_W-1:0]  on_reg;
      logic [pwm_timer_pkg::CNT_W-1:0]  sh_hi;
      logic [pwm_timer_pkg::CNT_W-1:0]  sh_lo;
      logic [pwm_timer_pkg::CNT_W-1:0]  phase_cnt;
      logic [pwm_timer_pkg::CNT_W-1:0]  on_cnt;
      pwm_timer_pkg::phase_state_t      st;
      logic [pwm_timer_pkg::ACC_W-1:0]  acc_f;
      logic [pwm_timer_pkg::ACC_W-1:0]  acc_s;
      logic [2:0]                       fdiv;
      logic [3:0]                       d10;
      logic                             bclk;
      logic                             out_p;
      logic                             out_n;
      logic                             irq_pulse;
      logic                             irq_stat;
      logic                             irq_mask;
      logic [pwm_timer_pkg::DATA_W-1:0] rd_data;
   } timer_state_t;

   timer_state_t                     s_r;
   timer_state_t                     s_nxt;
   logic [pwm_timer_pkg::ACC_W-1:0]  fsum;
   logic [pwm_timer_pkg::ACC_W-1:0]  ssum;
   logic                             base_f;
   logic                             base_s;
   logic [2:0]                       div_mask;
   logic                             tick;
   logic                             on_tick;
   logic                             run;
   logic                             burst;
   logic                             do_reload;

   assign run   = s_r.ctrl[pwm_timer_pkg::CTRL_RUN_BIT];
   assign burst = s_r.ctrl[pwm_timer_pkg::CTRL_BURST_BIT];

   always_comb
   begin
      s_nxt     = s_r;
      s_nxt.irq_pulse = 1'b0;
      s_nxt.rd_data   = '0;
      do_reload = 1'b0;

      // Rate accumulators give exact average 16 MHz and 32 kHz ticks.
      fsum   = s_r.acc_f + pwm_timer_pkg::FAST_BASE_HZ; // R02
      base_f = (fsum >= pwm_timer_pkg::SYS_CLK_HZ);
      s_nxt.acc_f = base_f ? (fsum - pwm_timer_pkg::SYS_CLK_HZ) : fsum;
      ssum   = s_r.acc_s + pwm_timer_pkg::SLOW_HZ;
      base_s = (ssum >= pwm_timer_pkg::SYS_CLK_HZ);
      s_nxt.acc_s = base_s ? (ssum - pwm_timer_pkg::SYS_CLK_HZ) : ssum;

      case (s_r.clkper[pwm_timer_pkg::CLKP_DIV_LSB +: 2])
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         2'h3:    div_mask = 3'h7;
         default: div_mask = 3'h0;
      endcase
      if (base_f)
      begin
         s_nxt.fdiv = s_r.fdiv + 3'h1;
      end

      // The fast rates run only with both select and enable set.
      if (s_r.ctrl[pwm_timer_pkg::CTRL_CSS_BIT])
      begin
         tick = base_f && s_r.clkper[pwm_timer_pkg::CLKP_EN_BIT] // R03
                && ((s_r.fdiv & div_mask) == 3'h0);
      end
      else
      begin
         tick = base_s; // R02
      end

      // The divide by ten slows only the ON-counter.
      on_tick = tick && (!s_r.ctrl[pwm_timer_pkg::CTRL_DIV10_BIT] // R04
                         || (s_r.d10 == pwm_timer_pkg::DIV10_LAST));

      if (!run)
      begin
         s_nxt.st        = pwm_timer_pkg::ST_IDLE; // R13
         s_nxt.phase_cnt = pwm_timer_pkg::CNT_ZERO;
         s_nxt.on_cnt    = pwm_timer_pkg::CNT_ZERO;
         s_nxt.sh_hi     = pwm_timer_pkg::CNT_ZERO;
         s_nxt.sh_lo     = pwm_timer_pkg::CNT_ZERO;
         s_nxt.d10       = 4'h0;
         s_nxt.bclk      = 1'b0;
      end
      else if (!s_r.freeze) // R16
      begin
         if (s_r.st == pwm_timer_pkg::ST_IDLE)
         begin
            // Counters and output start low, so the start is an interrupt point.
            do_reload = 1'b1; // R12
         end
         else if (tick)
         begin
            if (s_r.ctrl[pwm_timer_pkg::CTRL_DIV10_BIT])
            begin
               s_nxt.d10 = (s_r.d10 == pwm_timer_pkg::DIV10_LAST) ?
                           4'h0 : s_r.d10 + 4'h1;
            end
            if (on_tick && (s_r.on_cnt != pwm_timer_pkg::CNT_ZERO))
            begin
               s_nxt.on_cnt = s_r.on_cnt - pwm_timer_pkg::CNT_ONE; // R09
            end
            if (s_r.st == pwm_timer_pkg::ST_HIGH)
            begin
               s_nxt.bclk = !s_r.bclk; // R08
            end
            if (s_r.phase_cnt == pwm_timer_pkg::CNT_ZERO)
            begin
               if ((s_r.st == pwm_timer_pkg::ST_LOW)
                   && (s_r.on_cnt == pwm_timer_pkg::CNT_ZERO))
               begin
                  do_reload = 1'b1; // R09
               end
               else if (s_r.st == pwm_timer_pkg::ST_HIGH)
               begin
                  s_nxt.st        = pwm_timer_pkg::ST_LOW; // R06
                  s_nxt.phase_cnt = s_r.sh_lo;
               end
               else
               begin
                  s_nxt.st        = pwm_timer_pkg::ST_HIGH; // R06
                  s_nxt.phase_cnt = s_r.sh_hi;
                  s_nxt.bclk      = 1'b1;
               end
            end
            else
            begin
               s_nxt.phase_cnt = s_r.phase_cnt - pwm_timer_pkg::CNT_ONE;
            end
         end
      end

      if (do_reload)
      begin
         s_nxt.st        = pwm_timer_pkg::ST_HIGH; // R05
         s_nxt.phase_cnt = s_r.high_reg; // R10
         s_nxt.sh_hi     = s_r.high_reg; // R11
         s_nxt.sh_lo     = s_r.low_reg; // R11
         s_nxt.on_cnt    = s_r.on_reg; // R10
         s_nxt.d10       = 4'h0;
         s_nxt.bclk      = 1'b1;
         s_nxt.irq_pulse = 1'b1; // R18
      end

      // A new event wins over a clear in the same cycle.
      s_nxt.irq_stat = s_r.irq_stat;
      if (reg_wr && (reg_addr == pwm_timer_pkg::ADDR_IRQ_STAT)
          && reg_wdata[pwm_timer_pkg::IRQ_EV_BIT])
      begin
         s_nxt.irq_stat = 1'b0;
      end
      if (s_nxt.irq_pulse)
      begin
         s_nxt.irq_stat = 1'b1;
      end

      if (reg_wr)
      begin
         case (reg_addr)
            pwm_timer_pkg::ADDR_CTRL:
            begin
               s_nxt.ctrl = reg_wdata[pwm_timer_pkg::CTRL_W-1:0];
            end
            pwm_timer_pkg::ADDR_HIGH:
            begin
               s_nxt.high_reg = reg_wdata[pwm_timer_pkg::CNT_W-1:0]; // R17
            end
            pwm_timer_pkg::ADDR_LOW:
            begin
               s_nxt.low_reg = reg_wdata[pwm_timer_pkg::CNT_W-1:0]; // R17
            end
            pwm_timer_pkg::ADDR_ON:
            begin
               s_nxt.on_reg = reg_wdata[pwm_timer_pkg::CNT_W-1:0]; // R17
            end
            pwm_timer_pkg::ADDR_CLKPER:
            begin
               s_nxt.clkper = reg_wdata[pwm_timer_pkg::CLKP_W-1:0];
            end
            pwm_timer_pkg::ADDR_SET_FRZ:
            begin
               if (reg_wdata[pwm_timer_pkg::FRZ_BIT])
               begin
                  s_nxt.freeze = 1'b1; // R16
               end
            end
            pwm_timer_pkg::ADDR_CLR_FRZ:
            begin
               if (reg_wdata[pwm_timer_pkg::FRZ_BIT])
               begin
                  s_nxt.freeze = 1'b0; // R16
               end
            end
            pwm_timer_pkg::ADDR_IRQ_MASK:
            begin
               s_nxt.irq_mask = reg_wdata[pwm_timer_pkg::IRQ_EV_BIT];
            end
            default:
            begin
               s_nxt.freeze = s_nxt.freeze;
            end
         endcase
      end

      // Outputs use the mode being written, so they agree with the control register.
      s_nxt.out_p = (s_nxt.st == pwm_timer_pkg::ST_HIGH) // R07
                    && (!s_nxt.ctrl[pwm_timer_pkg::CTRL_BURST_BIT] || s_nxt.bclk); // R08
      s_nxt.out_n = !s_nxt.out_p; // R07

      if (reg_rd)
      begin
         case (reg_addr)
            pwm_timer_pkg::ADDR_CTRL:
            begin
               s_nxt.rd_data[pwm_timer_pkg::CTRL_W-1:0] = s_r.ctrl;
            end
            pwm_timer_pkg::ADDR_HIGH,
            pwm_timer_pkg::ADDR_LOW:
            begin
               s_nxt.rd_data[pwm_timer_pkg::CNT_W-1:0] = s_r.phase_cnt; // R15
            end
            pwm_timer_pkg::ADDR_ON:
            begin
               s_nxt.rd_data[pwm_timer_pkg::CNT_W-1:0] = s_r.on_cnt; // R14
            end
            pwm_timer_pkg::ADDR_CLKPER:
            begin
               s_nxt.rd_data[pwm_timer_pkg::CLKP_W-1:0] = s_r.clkper;
            end
            pwm_timer_pkg::ADDR_SET_FRZ,
            pwm_timer_pkg::ADDR_CLR_FRZ:
            begin
               s_nxt.rd_data[pwm_timer_pkg::FRZ_BIT] = s_r.freeze;
            end
            pwm_timer_pkg::ADDR_IRQ_STAT:
            begin
               s_nxt.rd_data[pwm_timer_pkg::IRQ_EV_BIT] = s_r.irq_stat;
            end
            pwm_timer_pkg::ADDR_IRQ_MASK:
            begin
               s_nxt.rd_data[pwm_timer_pkg::IRQ_EV_BIT] = s_r.irq_mask;
            end
            default:
            begin
               s_nxt.rd_data = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_r <= '0; // R01
         // The secondary output idles high as the inverse of the low primary.
         s_r.out_n <= 1'b1; // R07
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata          = s_r.rd_data;
   assign primary_pulse_out  = s_r.out_p;
   assign inverted_pulse_out = s_r.out_n;
   assign timer_interrupt    = s_r.irq_pulse;
   assign irq                = s_r.irq_stat && s_r.irq_mask;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_idle_reset: assert property ( // R13
      !run |=> (s_r.st == pwm_timer_pkg::ST_IDLE)
               && (s_r.phase_cnt == 16'h0000) && (s_r.on_cnt == 16'h0000)
               && !primary_pulse_out)
      else $error("disabled timer not held in reset");

   a_start_irq: assert property ( // R12
      run && !s_r.freeze && (s_r.st == pwm_timer_pkg::ST_IDLE)
      |=> timer_interrupt && (s_r.st == pwm_timer_pkg::ST_HIGH)
          && (s_r.phase_cnt == $past(s_r.high_reg))
          && (s_r.on_cnt == $past(s_r.on_reg)))
      else $error("start did not load and interrupt");

   a_out_inverse: assert property ( // R07
      inverted_pulse_out == !primary_pulse_out)
      else $error("outputs not complementary");

   a_steady_high: assert property ( // R07
      !burst |-> primary_pulse_out == (s_r.st == pwm_timer_pkg::ST_HIGH))
      else $error("primary output does not follow phase");

   a_phase_flip: assert property ( // R06
      run && !s_r.freeze && (s_r.st != pwm_timer_pkg::ST_IDLE) && tick
      && (s_r.phase_cnt == 16'h0000)
      |=> s_r.st != $past(s_r.st))
      else $error("phase did not flip at zero");

   a_on_hold: assert property ( // R09
      run && (s_r.st != pwm_timer_pkg::ST_IDLE) && (s_r.on_cnt == 16'h0000)
      |=> (s_r.on_cnt == 16'h0000) || timer_interrupt)
      else $error("on counter left zero without interrupt");

   a_shadow_hold: assert property ( // R11
      run && (s_r.st != pwm_timer_pkg::ST_IDLE)
      |=> ($stable(s_r.sh_hi) && $stable(s_r.sh_lo)) || timer_interrupt)
      else $error("shadow changed outside interrupt point");

   a_freeze_hold: assert property ( // R16
      run && s_r.freeze
      |=> $stable(s_r.phase_cnt) && $stable(s_r.on_cnt) && $stable(s_r.st))
      else $error("counters moved while frozen");

   a_read_on: assert property ( // R14
      reg_rd && (reg_addr == pwm_timer_pkg::ADDR_ON)
      |=> reg_rdata == {16'h0000, $past(s_r.on_cnt)})
      else $error("on address did not return live counter");

   a_read_phase: assert property ( // R15
      reg_rd && (reg_addr == pwm_timer_pkg::ADDR_LOW)
      |=> reg_rdata == {16'h0000, $past(s_r.phase_cnt)})
      else $error("reload address did not return phase counter");

   a_irq_single: assert property ( // R18
      timer_interrupt |=> !timer_interrupt)
      else $error("interrupt pulse longer than one cycle");

endmodule : dual_phase_pwm_timer

//--- verification/pin_monitor.sv
module pin_monitor
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic primary_pulse_out,
   input  wire logic inverted_pulse_out,
   input  wire logic timer_interrupt,
   output int        rise_cnt,
   output int        inv_bad
);
   timeunit 1ns;
   timeprecision 1ps;

   logic prev_r;
   logic armed_r;
   logic irq_prev_r;

   // The first edge after reset still sees the reset levels, so it is skipped.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_r   <= 1'h0;
         armed_r  <= 1'h0;
         irq_prev_r <= 1'h0;
         rise_cnt <= 0;
         inv_bad  <= 0;
      end
      else
      begin
         prev_r  <= primary_pulse_out;
         armed_r <= 1'h1;
         irq_prev_r <= timer_interrupt;
         if (primary_pulse_out === 1'h1 && prev_r === 1'h0)
            rise_cnt <= rise_cnt + 1;
         // Also counted: an interrupt pulse that stands for two cycles.
         if (armed_r && (inverted_pulse_out !== ~primary_pulse_out
                         || (timer_interrupt === 1'h1 && irq_prev_r === 1'h1)))
            inv_bad <= inv_bad + 1;
      end
   end
endmodule : pin_monitor

//--- verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        primary_pulse_out;
   logic        inverted_pulse_out;
   logic        timer_interrupt;
   logic        irq;
   int          rise_cnt;
   int          inv_bad;
   int          err_total;
   int          n_checks;
   int          cyc;
   int          rises;
   int          rise_base;
   logic [31:0] v;
   logic [31:0] w;
   logic [15:0] h;
   logic [15:0] l;
   logic [1:0]  dv;
   logic        bst;

   dual_phase_pwm_timer i_dut
   (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .reg_addr           (reg_addr),
      .reg_wdata          (reg_wdata),
      .reg_wr             (reg_wr),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .primary_pulse_out  (primary_pulse_out),
      .inverted_pulse_out (inverted_pulse_out),
      .timer_interrupt    (timer_interrupt),
      .irq                (irq)
   );

   pin_monitor i_pins
   (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .primary_pulse_out  (primary_pulse_out),
      .inverted_pulse_out (inverted_pulse_out),
      .timer_interrupt    (timer_interrupt),
      .rise_cnt           (rise_cnt),
      .inv_bad            (inv_bad)
   );

   initial
   begin
      core_clk = 1'h0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge core_clk);
      reg_wr    <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge core_clk);
      reg_rd   <= 1'h0;
      #1;
      d = reg_rdata;
   endtask : rd

   // Cycles up to the next interrupt pulse, and rising edges of the pin since the last one.
   task automatic wait_int();
      cyc = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         cyc++;
         if (cyc > 20000)
         begin
            err_total++;
            test_done();
         end
      end
      while (timer_interrupt !== 1'h1);
      rises     = rise_cnt - rise_base;
      rise_base = rise_cnt;
   endtask : wait_int

   // Interrupt spacing window for a given tick count and fast divider.
   function automatic logic in_win(int c, int n, int m);
      return c >= n * 15 * m && c <= n * 16 * m;
   endfunction : in_win

   initial
   begin
      sys_rst   = 1'h1;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'h0;
      reg_rd    = 1'h0;
      err_total = 0;
      n_checks  = 0;
      rise_base = 0;
      void'($urandom(42));
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'h0;

      rd(pwm_timer_pkg::ADDR_ON, v);
      chk(v, 32'h0);
      rd(pwm_timer_pkg::ADDR_HIGH, v);
      chk(v, 32'h0);
      rd(pwm_timer_pkg::ADDR_CTRL, v);
      chk(v, 32'h0);
      rd(8'hFC, v);
      chk(v, 32'h0);
      $display("test reset done");

      for (int k = 0; k < 4; k++)
      begin
         dv  = k[1:0];
         bst = 1'($urandom_range(0, 1));
         h   = 16'($urandom_range(0, 3));
         l   = 16'($urandom_range(0, 3));
         wr(pwm_timer_pkg::ADDR_HIGH, {16'h0, h});
         wr(pwm_timer_pkg::ADDR_LOW, {16'h0, l});
         wr(pwm_timer_pkg::ADDR_ON, 32'h0);
         wr(pwm_timer_pkg::ADDR_CLKPER, {29'h0, dv, 1'h1});
         wr(pwm_timer_pkg::ADDR_CTRL, {28'h0, bst, 3'h5});
         wait_int();
         chk(32'(cyc <= 3), 32'h1);
         wait_int();
         wr(pwm_timer_pkg::ADDR_HIGH, 32'h3);
         wr(pwm_timer_pkg::ADDR_LOW, 32'h2);
         wait_int();
         // The two reload writes above take four cycles of this period.
         chk(32'(in_win(cyc + 4, h + l + 2, 1 << dv)), 32'h1);
         chk(32'(rises), bst ? 32'((h + 2) / 2) : 32'h1);
         wait_int();
         chk(32'(in_win(cyc, 7, 1 << dv)), 32'h1);
         wr(pwm_timer_pkg::ADDR_CTRL, 32'h0);
         rd(pwm_timer_pkg::ADDR_HIGH, v);
         chk(v, 32'h0);
         chk({31'h0, primary_pulse_out}, 32'h0);
      end
      $display("test pwm periods done");

      wr(pwm_timer_pkg::ADDR_HIGH, 32'h0);
      wr(pwm_timer_pkg::ADDR_LOW, 32'h0);
      wr(pwm_timer_pkg::ADDR_ON, 32'h1);
      wr(pwm_timer_pkg::ADDR_CLKPER, 32'h1);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h7);
      wait_int();
      wait_int();
      wait_int();
      // Ten ticks to empty the ON-counter, then two more to end a low phase.
      chk(32'(in_win(cyc, 12, 1)), 32'h1);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h0);
      $display("test divide by ten done");

      wr(pwm_timer_pkg::ADDR_HIGH, 32'hC8);
      wr(pwm_timer_pkg::ADDR_ON, 32'h5);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h5);
      rd(pwm_timer_pkg::ADDR_ON, v);
      chk(32'(v == 32'h5 || v == 32'h4), 32'h1);
      rd(pwm_timer_pkg::ADDR_LOW, v);
      chk(32'(v == 32'hC8 || v == 32'hC7), 32'h1);
      wr(pwm_timer_pkg::ADDR_SET_FRZ, 32'h1);
      rd(pwm_timer_pkg::ADDR_HIGH, v);
      repeat (100) @(posedge core_clk);
      rd(pwm_timer_pkg::ADDR_HIGH, w);
      chk(w, v);
      rd(pwm_timer_pkg::ADDR_SET_FRZ, v);
      chk(v, 32'h1);
      wr(pwm_timer_pkg::ADDR_CLR_FRZ, 32'h1);
      repeat (100) @(posedge core_clk);
      rd(pwm_timer_pkg::ADDR_HIGH, v);
      chk(32'(v != w), 32'h1);
      $display("test live reads and freeze done");

      rd(pwm_timer_pkg::ADDR_IRQ_STAT, v);
      chk(v, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(pwm_timer_pkg::ADDR_IRQ_MASK, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h1);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h0);
      wr(pwm_timer_pkg::ADDR_IRQ_STAT, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt status done");

      wr(pwm_timer_pkg::ADDR_HIGH, 32'h0);
      wr(pwm_timer_pkg::ADDR_ON, 32'h0);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h4);
      wait_int();
      chk(32'(cyc <= 3), 32'h1);
      wait_int();
      wait_int();
      // Two slow ticks, each 7812 or 7813 clock cycles apart.
      chk(32'(cyc >= 15624 && cyc <= 15626), 32'h1);
      wr(pwm_timer_pkg::ADDR_CTRL, 32'h0);
      chk(32'(inv_bad), 32'h0);
      $display("test slow clock done");
      test_done();
   end
endmodule : testbench
